// ---- core/file_ram.sv ----
// small file register memory with registered read data
`timescale 1ns/1ns
module file_ram
	import ret_rot_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   we,
	input  wire logic [FADDR_W-1:0]     waddr,
	input  wire logic [DATA_W-1:0]      wdata,
	input  wire logic [FADDR_W-1:0]     raddr,
	output logic      [DATA_W-1:0]      rdata
);
	logic [DATA_W-1:0] mem [FILE_DEPTH];

	// each entry clears to its own address so rotates start from known data
	genvar i;
	generate
		for (i = 0; i < FILE_DEPTH; i++) begin : g_entry
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					mem[i] <= DATA_W'(i);
				end else if (we && (waddr == FADDR_W'(i))) begin
					mem[i] <= wdata;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		rdata <= mem[raddr];
	end
endmodule : file_ram

// ---- core/ret_rot_pkg.sv ----
// constants shared by the return and rotate execution unit
package ret_rot_pkg;
	localparam int          DATA_W      = 8;
	localparam int          PC_W        = 15;
	localparam int          FADDR_W     = 7;
	localparam int          OPC_W       = 3;
	localparam int          FILE_DEPTH  = 128;
	localparam int          GLOBAL_INT_EN_BIT = 7;
	localparam int          CARRY_BIT   = 0;
	localparam logic [7:0]  INT_CTRL_RST = 8'h00;
	localparam logic [7:0]  STATUS_RST  = 8'h00;
	localparam logic [7:0]  WREG_RST    = 8'h00;
	localparam logic [14:0] PC_RST      = 15'h0000;
	localparam logic [7:0]  FILE_RST    = 8'h00;
	localparam int          RET_CYCLES  = 2;
	localparam int          ROT_CYCLES  = 1;
	// operation codes presented on the issue port
	localparam logic [2:0]  OP_NOP      = 3'h0;
	localparam logic [2:0]  OP_RETFI    = 3'h1;
	localparam logic [2:0]  OP_RETURN   = 3'h2;
	localparam logic [2:0]  OP_RETLIT   = 3'h3;
	localparam logic [2:0]  OP_ROTL     = 3'h4;
endpackage : ret_rot_pkg

// ---- core/ret_rot_unit.sv ----
// execution unit for the three return operations and rotate left through carry
// Notes on behaviour
// - interrupt return pops stack into PC
// - interrupt return sets global interrupt enable
// - interrupt return two cycles, flags unchanged
// - subroutine return pops stack, two cycles
// - literal return loads literal into working register
// - literal return reloads PC, two cycles
// - rotate file register left through carry
// - destination bit picks working or file register
`timescale 1ns/1ns
module ret_rot_unit
(
	input  wire logic                              CLK,
	input  wire logic                              RESETN,
	input  wire logic                              ISSUE,
	input  wire logic [ret_rot_pkg::OPC_W-1:0]     OPCODE,
	input  wire logic [ret_rot_pkg::DATA_W-1:0]    LITERAL,
	input  wire logic [ret_rot_pkg::FADDR_W-1:0]   FILE_ADDR,
	input  wire logic                              DEST,
	input  wire logic [ret_rot_pkg::PC_W-1:0]      TOP_OF_STACK,
	output logic                                   READY,
	output logic                                   STACK_POP,
	output logic                                   DONE,
	output logic [ret_rot_pkg::PC_W-1:0]           PC,
	output logic [ret_rot_pkg::DATA_W-1:0]         WREG,
	output logic [ret_rot_pkg::DATA_W-1:0]         STATUS,
	output logic [ret_rot_pkg::DATA_W-1:0]         INTERRUPT_CONTROL_REG,
	output logic [ret_rot_pkg::DATA_W-1:0]         FILE_DATA
);
	import ret_rot_pkg::*;

	typedef enum logic [1:0] {IDLE, RET_WAIT, ROT_READ} state_e;

	state_e               state;
	// operands latched at issue so the inputs may move on
	logic [OPC_W-1:0]     op;
	logic [DATA_W-1:0]    lit;
	logic [FADDR_W-1:0]   faddr;
	logic                 dest;

	// rotate datapath
	logic [DATA_W-1:0]    rdata;
	logic [DATA_W-1:0]    rot;
	logic                 rot_carry;
	logic                 fwe;

	// decode and completion strobes
	logic                 accept;
	logic                 op_is_ret;
	logic                 op_is_rot;
	logic                 issue_ret;
	logic                 issue_rot;
	logic                 ret_done;
	logic                 rot_done;
	logic                 retfi_done;
	logic                 retlit_done;
	logic                 rot_to_wreg;
	logic                 rot_to_file;

	// opcodes 5 to 7 pass accept but start nothing
	assign accept      = ISSUE && READY && (OPCODE != OP_NOP);
	assign op_is_ret   = (OPCODE == OP_RETFI) || (OPCODE == OP_RETURN) || (OPCODE == OP_RETLIT);
	assign op_is_rot   = (OPCODE == OP_ROTL);
	assign issue_ret   = accept && op_is_ret;
	assign issue_rot   = accept && op_is_rot;
	assign ret_done    = (state == RET_WAIT);
	assign rot_done    = (state == ROT_READ);
	assign retfi_done  = ret_done && (op == OP_RETFI);
	assign retlit_done = ret_done && (op == OP_RETLIT);
	assign rot_to_wreg = rot_done && !dest;
	assign rot_to_file = rot_done && dest;
	assign fwe         = rot_to_file;

	// old carry enters bit 0, old bit 7 leaves as the new carry
	assign rot_carry = rdata[DATA_W-1];

	// bit 0 takes the carry, the other bits shift up by one
	genvar b;
	generate
		for (b = 0; b < DATA_W; b++) begin : g_rot_bit
			if (b == 0) begin : g_carry_in
				assign rot[b] = STATUS[CARRY_BIT];
			end else begin : g_shift
				assign rot[b] = rdata[b-1];
			end
		end
	endgenerate

	file_ram u_file_ram (
		.clk   (CLK),
		.rst_n (RESETN),
		.we    (fwe),
		.waddr (faddr),
		.wdata (rot),
		.raddr (FILE_ADDR),
		.rdata (rdata)
	);

	// returns spend their second cycle in RET_WAIT, rotate reads in ROT_READ
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state <= IDLE;
		end else begin
			case (state)
				IDLE: begin
					if (issue_rot) begin
						state <= ROT_READ;
					end else if (issue_ret) begin
						state <= RET_WAIT;
					end
				end
				RET_WAIT: state <= IDLE;
				ROT_READ: state <= IDLE;
				default:  state <= IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			op <= OP_NOP;
		end else if (accept) begin
			op <= OPCODE;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			lit <= WREG_RST;
		end else if (accept) begin
			lit <= LITERAL;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			faddr <= '0;
		end else if (accept) begin
			faddr <= FILE_ADDR;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			dest <= 1'b0;
		end else if (accept) begin
			dest <= DEST;
		end
	end

	// low for the one busy cycle; an issue then is dropped
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			READY <= 1'b1;
		end else begin
			READY <= !(issue_ret || issue_rot);
		end
	end

	// pop strobe on the closing edge of every return
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			STACK_POP <= 1'b0;
		end else begin
			STACK_POP <= ret_done;
		end
	end

	// popped return address taken on that same edge
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			PC <= PC_RST;
		end else if (ret_done) begin
			PC <= TOP_OF_STACK;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			DONE <= 1'b0;
		end else begin
			DONE <= ret_done || rot_done;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			INTERRUPT_CONTROL_REG <= INT_CTRL_RST;
		end else if (retfi_done) begin
			// the enable is only ever set here; only reset clears it
			INTERRUPT_CONTROL_REG[GLOBAL_INT_EN_BIT] <= 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			WREG <= WREG_RST;
		end else if (retlit_done) begin
			WREG <= lit;
		end else if (rot_to_wreg) begin
			WREG <= rot;
		end
	end

	// returns never touch status; rotate changes only the carry
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			STATUS <= STATUS_RST;
		end else if (rot_done) begin
			STATUS[CARRY_BIT] <= rot_carry;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			FILE_DATA <= FILE_RST;
		end else if (rot_done) begin
			FILE_DATA <= rot;
		end
	end
endmodule : ret_rot_unit

// ---- dv/ret_rot_assertions.sv ----
// checker for the return and rotate unit
`timescale 1ns/1ns
module ret_rot_assertions
	import ret_rot_pkg::*;
(
	input wire logic        CLK,
	input wire logic        RESETN,
	input wire logic        ISSUE,
	input wire logic [2:0]  OPCODE,
	input wire logic [7:0]  LITERAL,
	input wire logic        DEST,
	input wire logic [14:0] TOP_OF_STACK,
	input wire logic        READY,
	input wire logic        STACK_POP,
	input wire logic        DONE,
	input wire logic [14:0] PC,
	input wire logic [7:0]  WREG,
	input wire logic [7:0]  STATUS,
	input wire logic [7:0]  INTERRUPT_CONTROL_REG,
	input wire logic [7:0]  FILE_DATA
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	logic go;
	assign go = ISSUE && READY;
	a_retfi_pc_load:
	assert property (go && OPCODE == OP_RETFI |-> ##2 STACK_POP && PC == $past(TOP_OF_STACK))
		else $error("pc not reloaded");
	a_retfi_int_enable:
	assert property (go && OPCODE == OP_RETFI |-> ##2 INTERRUPT_CONTROL_REG[GLOBAL_INT_EN_BIT])
		else $error("enable not set");
	a_retfi_two_cycles:
	assert property (go && OPCODE == OP_RETFI |=> !DONE ##1 DONE && STATUS == $past(STATUS, 2))
		else $error("timing or flags wrong");
	a_ret_pop_pc:
	assert property (go && OPCODE == OP_RETURN |-> ##2 DONE && STACK_POP && PC == $past(TOP_OF_STACK))
		else $error("return wrong");
	a_lit_wreg_load:
	assert property (go && OPCODE == OP_RETLIT |-> ##2 WREG == $past(LITERAL, 2))
		else $error("literal not loaded");
	a_lit_pc_load:
	assert property (go && OPCODE == OP_RETLIT |-> ##2 DONE && STACK_POP && PC == $past(TOP_OF_STACK))
		else $error("literal return pc");
	a_rot_carry_in:
	assert property (go && OPCODE == OP_ROTL |-> ##2 FILE_DATA[0] === $past(STATUS[CARRY_BIT], 2))
		else $error("carry not rotated in");
	a_rot_dest_sel:
	assert property (go && OPCODE == OP_ROTL |-> ##2 WREG === ($past(DEST, 2) ? $past(WREG, 2) : FILE_DATA))
		else $error("wrong destination");
	a_rot_one_flag:
	assert property (go && OPCODE == OP_ROTL |-> ##2 DONE && !STACK_POP && STATUS[7:1] == 7'h00)
		else $error("rotate flags wrong");
endmodule : ret_rot_assertions

bind ret_rot_unit ret_rot_assertions chk_u (.*);

// ---- dv/testbench.sv ----
// self-checking bench for the return and rotate unit
`timescale 1ns/1ns
module testbench;
	import ret_rot_pkg::*;
	logic        CLK = 1'b0;
	logic        RESETN = 1'b0;
	logic        ISSUE = 1'b0;
	logic        DEST = 1'b0;
	logic [2:0]  OPCODE = 3'h0;
	logic [7:0]  LITERAL = 8'h00;
	logic [6:0]  FILE_ADDR = 7'h7F;
	logic [14:0] TOP_OF_STACK = 15'h0000;
	logic        READY, STACK_POP, DONE;
	logic [14:0] PC;
	logic [7:0]  WREG, STATUS, INTERRUPT_CONTROL_REG, FILE_DATA;
	logic [7:0]  s;
	int          err_count = 0;
	int          n_checks = 0;
	int          cyc = 0;
	ret_rot_unit dut_u (.*);
	initial begin
		forever #2 CLK = ~CLK;
	end
	task automatic print_verdict;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 400) begin
			err_count++;
			print_verdict();
		end
	end
	task automatic chk(input logic ok);
		n_checks++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("MISMATCH %0t result wrong", $time);
		end
	endtask : chk
	task automatic run(input logic [2:0] op, input logic [7:0] k, input logic d, input logic [14:0] t);
		@(posedge CLK);
		ISSUE <= 1'b1;
		OPCODE <= op;
		LITERAL <= k;
		DEST <= d;
		TOP_OF_STACK <= t;
		@(posedge CLK);
		ISSUE <= 1'b0;
		#1;
		chk(DONE === 1'b0 && READY === 1'b0);
		@(posedge CLK);
		#1;
		chk(DONE === 1'b1 && READY === 1'b1);
	endtask : run
	task automatic t_retfi;
		s = STATUS;
		run(OP_RETFI, 8'h00, 1'b0, 15'h7FFF);
		chk(PC === 15'h7FFF && STACK_POP === 1'b1);
		chk(INTERRUPT_CONTROL_REG[GLOBAL_INT_EN_BIT] === 1'b1);
		chk(STATUS === s);
	endtask : t_retfi
	task automatic t_return;
		run(OP_RETURN, 8'h00, 1'b0, 15'h0001);
		chk(PC === 15'h0001 && STACK_POP === 1'b1 && STATUS === s);
	endtask : t_return
	task automatic t_retlit;
		run(OP_RETLIT, 8'hFF, 1'b0, 15'h2AAA);
		chk(WREG === 8'hFF && STATUS === s);
		run(OP_RETLIT, 8'h00, 1'b0, 15'h5555);
		chk(WREG === 8'h00 && PC === 15'h5555);
	endtask : t_retlit
	task automatic t_rot;
		logic [7:0] f;
		logic       c;
		run(OP_ROTL, 8'h00, 1'b1, 15'h0000);
		chk(FILE_DATA[0] === STATUS_RST[CARRY_BIT] && (^FILE_DATA) !== 1'bx);
		f = FILE_DATA;
		c = STATUS[CARRY_BIT];
		run(OP_ROTL, 8'h00, 1'b1, 15'h0000);
		chk(FILE_DATA === {f[6:0], c} && STATUS[CARRY_BIT] === f[7]);
		f = FILE_DATA;
		c = STATUS[CARRY_BIT];
		run(OP_ROTL, 8'h00, 1'b0, 15'h0000);
		chk(WREG === {f[6:0], c} && STATUS[7:1] === 7'h00 && PC === 15'h5555);
		c = STATUS[CARRY_BIT];
		run(OP_ROTL, 8'h00, 1'b1, 15'h0000);
		chk(FILE_DATA === {f[6:0], c} && STATUS[CARRY_BIT] === f[7]);
	endtask : t_rot
	task automatic t_reset;
		@(posedge CLK);
		RESETN <= 1'b0;
		@(posedge CLK);
		#1;
		chk(READY === 1'b1 && DONE === 1'b0 && STACK_POP === 1'b0 && PC === PC_RST);
		chk(WREG === WREG_RST && STATUS === STATUS_RST);
		chk(INTERRUPT_CONTROL_REG === INT_CTRL_RST && FILE_DATA === FILE_RST);
		@(posedge CLK);
		RESETN <= 1'b1;
		run(OP_RETURN, 8'h00, 1'b0, 15'h1234);
		chk(PC === 15'h1234 && INTERRUPT_CONTROL_REG[GLOBAL_INT_EN_BIT] === 1'b0);
	endtask : t_reset
	initial begin
		repeat (6) @(posedge CLK);
		RESETN <= 1'b1;
		t_retfi();
		t_return();
		t_retlit();
		t_rot();
		t_reset();
		print_verdict();
	end
endmodule : testbench
